//--- sfps_pkg.sv
package sfps_pkg;
  // command codes on the link
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_PROG4 = 8'h12;
  localparam logic [7:0] OP_QUAD_PROG4 = 8'h34;
  localparam logic [7:0] OP_SUB_ERASE = 8'h20;
  localparam logic [7:0] OP_SEC_ERASE = 8'hd8;
  localparam logic [7:0] OP_DIE_ERASE = 8'hc4;
  localparam logic [7:0] OP_SUB_ERASE4 = 8'h21;
  localparam logic [7:0] OP_SEC_ERASE4 = 8'hdc;
  localparam logic [7:0] OP_ENTER4 = 8'hb7;
  localparam logic [7:0] OP_EXIT4 = 8'he9;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_CLR_FLAGS = 8'h50;
  // command plus address clocks per line count
  localparam int CA_SINGLE_BASE = 7;
  localparam int CA_DUAL_BASE = 3;
  localparam int CA_QUAD_BASE = 1;
  // internal operation times in microseconds
  localparam int CLK_MHZ = 250;
  localparam int PAGE_PROGRAM_TIME_US = 120;
  localparam int SUBSECTOR_ERASE_TIME_US = 400;
  localparam int SECTOR_ERASE_TIME_US = 700;
  localparam int DIE_ERASE_TIME_US = 2000;
  localparam int TIMEOUT_FACTOR = 4;
  localparam int PP_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SSE_CYC = SUBSECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int SE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int DE_CYC = DIE_ERASE_TIME_US * CLK_MHZ;
  // flag register bit positions
  localparam int FL_PROTECT = 1;
  localparam int FL_PSUSP = 2;
  localparam int FL_PFAIL = 4;
  localparam int FL_EFAIL = 5;
  localparam int FL_ESUSP = 6;
  localparam int FL_READY = 7;
  localparam logic [7:0] FLAG_RST = 8'h80;
  typedef enum logic [1:0] {K_PROG = 2'h0, K_SUB = 2'h1, K_SEC = 2'h2, K_DIE = 2'h3} sfps_kind_t;
endpackage

//--- sfps_sequencer.sv
`timescale 1ns/1ns
// Overview of operation
// - 12h and 34h carry 32-bit address
// - addressing width by config bit or commands
// - 4-byte commands always four address bytes
// - address phase clocks depend on line count
// - program runs self-timed for program time
// - erase returns cells to one
// - erase without write enable is discarded
// - no boundary raise: nothing done, latch kept
// - protected subsector erase refused, flags 1,5
// - busy: controller flag zero, wip one
// - end: wip zero, latch cleared always
// - erase timeout: latch clear, erase error
// - status pollable, ready returns to one
// - erase time chosen by command kind
// - region erase, any inside address selects
// - address bits taken on rising edge
// - subsector and sector erase suspendable
// - die erase sets whole array to ones
// - die erase refused when any sector locked
// - program needs write enable first
// - protected program refused, flags 1,4
// - program data wraps within page
// - program timeout: latch clear, fail flag
module sfps_sequencer #(
  parameter int PAGE_BYTES = 256,
  parameter int PP_CYCLES = sfps_pkg::PP_CYC,
  parameter int SSE_CYCLES = sfps_pkg::SSE_CYC,
  parameter int SE_CYCLES = sfps_pkg::SE_CYC,
  parameter int DE_CYCLES = sfps_pkg::DE_CYC,
  parameter int TIMEOUT_CYCLES = sfps_pkg::DE_CYC * sfps_pkg::TIMEOUT_FACTOR
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic linkClk,
  input wire logic selectN,
  input wire logic [3:0] dqIn,
  input wire logic [1:0] lineMode,
  input wire logic cfgAddr4,
  input wire logic protectHit,
  input wire logic anyLocked,
  input wire logic arrayStall,
  output logic writeEnable,
  output logic writeInProgress,
  output logic [7:0] flagStatus,
  output logic addr4Active,
  output logic opStart,
  output logic opDone,
  output logic opErase,
  output sfps_pkg::sfps_kind_t opKind,
  output logic [31:0] fullWordAddress,
  output logic [7:0] pageData,
  output logic [7:0] pageIndex,
  output logic pageWrite
);
  import sfps_pkg::*;

  // ---------------- link domain ----------------
  // bits per clock from line mode: 0 single, 1 dual, 2 quad
  logic [7:0] shiftR;
  logic [5:0] bitCntR;
  logic [7:0] opcodeR;
  logic [31:0] addrR;
  logic [2:0] byteCntR;
  logic gotOpR;
  logic onBoundR;
  logic [7:0] dataByteR;
  logic [7:0] dataIdxR;
  // toggle starts at zero; the core side only looks for changes
  logic dataTogR = 1'b0;
  logic [7:0] dataIdxR_hold;
  logic [7:0] lastBits;
  logic [2:0] step;
  logic [2:0] stepBits;
  logic lnk4;
  logic lnkCfg4Meta;
  logic lnkCfg4;
  logic opcodeIsProg;
  // armed by selectN high: next clock edge starts a fresh frame
  logic armR;
  logic [7:0] curShift;
  logic [5:0] curBitCnt;
  logic curGotOp;
  logic [2:0] curByteCnt;
  logic [7:0] curIdx;
  logic byteEnd;

  // frame state seen as cleared at the first edge of a frame, so the last
  // frame's fields stay readable by the core after selectN rises
  always_comb begin
    curShift = armR ? 8'h00 : shiftR;
    curBitCnt = armR ? 6'd0 : bitCntR;
    curGotOp = armR ? 1'b0 : gotOpR;
    curByteCnt = armR ? 3'd0 : byteCntR;
    curIdx = armR ? 8'h00 : dataIdxR;
    step = (lineMode == 2'd2) ? 3'd4 : (lineMode == 2'd1) ? 3'd2 : 3'd1;
    stepBits = step;
    // msb first; the highest line carries the earliest bit of each group
    unique case (lineMode)
      2'd2: lastBits = {curShift[3:0], dqIn[3:0]};
      2'd1: lastBits = {curShift[5:0], dqIn[1:0]};
      default: lastBits = {curShift[6:0], dqIn[0]};
    endcase
    byteEnd = (curBitCnt + 6'(stepBits)) >= 6'd8;
  end

  // frame start marker, set while deselected
  always_ff @(posedge linkClk or posedge selectN) begin
    if (selectN) begin
      armR <= 1'b1;
    end else begin
      armR <= 1'b0;
    end
  end

  // mode bit brought into link domain
  always_ff @(posedge linkClk) begin
    lnkCfg4Meta <= addr4Active;
    lnkCfg4 <= lnkCfg4Meta;
  end

  // dedicated 4-byte opcodes ignore the mode setting
  // four byte override
  assign lnk4 = (opcodeR == OP_PROG4) || (opcodeR == OP_QUAD_PROG4) || (opcodeR == OP_SUB_ERASE4)
                || (opcodeR == OP_SEC_ERASE4) || lnkCfg4;

  // shift in on rising edge while selected; selectN high restarts the frame
  // rising edge capture
  always_ff @(posedge linkClk) begin
    if (!selectN) begin
      gotOpR <= curGotOp;
      byteCntR <= curByteCnt;
      dataIdxR <= curIdx;
      if (byteEnd) begin
        bitCntR <= 6'd0;
        onBoundR <= 1'b1;
        if (!curGotOp) begin
          opcodeR <= lastBits;
          gotOpR <= 1'b1;
        end else if (curByteCnt < (lnk4 ? 3'd4 : 3'd3)) begin
          addrR <= {addrR[23:0], lastBits};
          byteCntR <= curByteCnt + 3'd1;
        end else begin
          dataIdxR <= curIdx + 8'd1;
        end
        shiftR <= 8'h00;
      end else begin
        bitCntR <= curBitCnt + 6'(stepBits);
        onBoundR <= 1'b0;
        shiftR <= lastBits;
      end
    end
  end

  // data bytes handed across with a toggle, byte and index held stable
  always_ff @(posedge linkClk) begin
    if (!selectN && curGotOp && curByteCnt == (lnk4 ? 3'd4 : 3'd3) && byteEnd) begin
      dataByteR <= lastBits;
      dataIdxR_hold <= addrR[7:0] + curIdx;
      dataTogR <= ~dataTogR;
    end
  end

  // ---------------- core domain ----------------
  // frame end seen as selectN rising after synchroniser
  logic selMetaR;
  logic selSyncR;
  logic selPrevR;
  logic togMetaR;
  logic togSyncR;
  logic togPrevR;
  logic frameEnd;
  assign frameEnd = clkEn && selSyncR && !selPrevR;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      selMetaR <= 1'b1;
      selSyncR <= 1'b1;
      selPrevR <= 1'b1;
      togMetaR <= 1'b0;
      togSyncR <= 1'b0;
      togPrevR <= 1'b0;
    end else if (clkEn) begin
      selMetaR <= selectN;
      selSyncR <= selMetaR;
      selPrevR <= selSyncR;
      togMetaR <= dataTogR;
      togSyncR <= togMetaR;
      togPrevR <= togSyncR;
    end
  end

  // page buffer write port: latest byte at wrapped index wins
  // last page kept
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pageWrite <= 1'b0;
      pageData <= 8'h00;
      pageIndex <= 8'h00;
    end else if (clkEn) begin
      pageWrite <= (togSyncR != togPrevR) && opcodeIsProg;
      pageData <= dataByteR;
      pageIndex <= 8'(dataIdxR_hold % PAGE_BYTES);
    end
  end

  // frame fields are stable once selectN is high
  logic opcodeIsErase;
  logic addrDone;
  assign opcodeIsProg = (opcodeR == OP_PAGE_PROG) || (opcodeR == OP_QUAD_PROG) ||
                        (opcodeR == OP_PROG4) || (opcodeR == OP_QUAD_PROG4);
  assign opcodeIsErase = (opcodeR == OP_SUB_ERASE) || (opcodeR == OP_SEC_ERASE) ||
                         (opcodeR == OP_DIE_ERASE) || (opcodeR == OP_SUB_ERASE4) ||
                         (opcodeR == OP_SEC_ERASE4);
  assign addrDone = byteCntR == (lnk4 ? 3'd4 : 3'd3);

  typedef enum logic [3:0] {S_IDLE = 4'b0001, S_BUSY = 4'b0010, S_SUSP = 4'b0100, S_END = 4'b1000} sfps_state_t;
  sfps_state_t stateR;
  logic [31:0] cntR;
  logic [31:0] toR;
  logic [31:0] limit;

  always_comb begin
    unique case (opKind)
      K_PROG: limit = 32'(PP_CYCLES);
      K_SUB: limit = 32'(SSE_CYCLES);
      K_SEC: limit = 32'(SE_CYCLES);
      default: limit = 32'(DE_CYCLES);
    endcase
  end

  // address mode by config bit or enter and exit commands
  // mode selection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr4Active <= 1'b0;
    end else if (clkEn) begin
      if (frameEnd && opcodeR == OP_ENTER4) begin
        addr4Active <= 1'b1;
      end else if (frameEnd && opcodeR == OP_EXIT4) begin
        addr4Active <= 1'b0;
      end else if (frameEnd && opcodeR == OP_WRITE_EN) begin
        addr4Active <= addr4Active | cfgAddr4;
      end
    end
  end

  // main sequencer, latch and flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stateR <= S_IDLE;
      writeEnable <= 1'b0;
      writeInProgress <= 1'b0;
      flagStatus <= FLAG_RST;
      cntR <= 32'h0;
      toR <= 32'h0;
      opStart <= 1'b0;
      opDone <= 1'b0;
      opErase <= 1'b0;
      opKind <= K_PROG;
      fullWordAddress <= 32'h0;
    end else if (clkEn) begin
      opStart <= 1'b0;
      opDone <= 1'b0;
      unique case (stateR)
        S_IDLE: begin
          if (frameEnd) begin
            if (opcodeR == OP_WRITE_EN) begin
              writeEnable <= 1'b1;
            end else if (opcodeR == OP_CLR_FLAGS) begin
              flagStatus[FL_PROTECT] <= 1'b0;
              flagStatus[FL_PFAIL] <= 1'b0;
              flagStatus[FL_EFAIL] <= 1'b0;
            end else if ((opcodeIsProg || opcodeIsErase) && onBoundR && addrDone) begin
              if (writeEnable) begin
                if (opcodeIsErase && opcodeR == OP_DIE_ERASE && anyLocked) begin
                  flagStatus[FL_PROTECT] <= 1'b1;
                  flagStatus[FL_EFAIL] <= 1'b1;
                end else if (protectHit) begin
                  flagStatus[FL_PROTECT] <= 1'b1;
                  flagStatus[opcodeIsErase ? FL_EFAIL : FL_PFAIL] <= 1'b1;
                end else begin
                  stateR <= S_BUSY;
                  writeInProgress <= 1'b1;
                  flagStatus[FL_READY] <= 1'b0;
                  opStart <= 1'b1;
                  opErase <= opcodeIsErase;
                  // region or die select; erase to ones
                  opKind <= (opcodeR == OP_DIE_ERASE) ? K_DIE :
                            (opcodeR == OP_SEC_ERASE || opcodeR == OP_SEC_ERASE4) ? K_SEC :
                            opcodeIsErase ? K_SUB : K_PROG;
                  fullWordAddress <= lnk4 ? addrR : {8'h00, addrR[23:0]};
                  cntR <= 32'h0;
                  toR <= 32'h0;
                end
              end
            end
          end
        end
        S_BUSY: begin
          toR <= toR + 32'd1;
          if (!arrayStall) begin
            cntR <= cntR + 32'd1;
          end
          if (frameEnd && opcodeR == OP_SUSPEND && opErase && opKind != K_DIE) begin
            stateR <= S_SUSP;
            flagStatus[FL_ESUSP] <= 1'b1;
            flagStatus[FL_READY] <= 1'b1;
          end else if (toR >= 32'(TIMEOUT_CYCLES)) begin
            stateR <= S_END;
            flagStatus[opErase ? FL_EFAIL : FL_PFAIL] <= 1'b1;
          end else if (cntR + 32'd1 >= limit) begin
            stateR <= S_END;
          end
        end
        S_SUSP: begin
          if (frameEnd && opcodeR == OP_RESUME) begin
            stateR <= S_BUSY;
            flagStatus[FL_ESUSP] <= 1'b0;
            flagStatus[FL_READY] <= 1'b0;
          end
        end
        default: begin
          stateR <= S_IDLE;
          writeInProgress <= 1'b0;
          writeEnable <= 1'b0;
          flagStatus[FL_READY] <= 1'b1;
          opDone <= 1'b1;
        end
      endcase
    end
  end

  // chk_busy_flags_pair
  chk_busy_flags_pair: assert property (@(posedge core_clk) disable iff (srst)
    stateR == S_BUSY |-> writeInProgress && !flagStatus[FL_READY])
    else $error("busy without wip");
  // chk_done_clears_latch
  chk_done_clears_latch: assert property (@(posedge core_clk) disable iff (srst)
    opDone |-> !writeEnable && !writeInProgress && flagStatus[FL_READY])
    else $error("done left latch or wip");
  // chk_start_needs_latch
  chk_start_needs_latch: assert property (@(posedge core_clk) disable iff (srst)
    opStart |-> $past(writeEnable))
    else $error("start without latch");
  // chk_no_restart_busy
  chk_no_restart_busy: assert property (@(posedge core_clk) disable iff (srst)
    opStart |-> $past(stateR) == S_IDLE)
    else $error("start while busy");
  // chk_refuse_keeps_latch
  chk_refuse_keeps_latch: assert property (@(posedge core_clk) disable iff (srst)
    $rose(flagStatus[FL_PROTECT]) |-> writeEnable)
    else $error("refusal dropped latch");
  // chk_die_locked_refused
  chk_die_locked_refused: assert property (@(posedge core_clk) disable iff (srst)
    opStart && opKind == K_DIE |-> !$past(anyLocked))
    else $error("locked die erase started");
  // chk_suspend_erase_only
  chk_suspend_erase_only: assert property (@(posedge core_clk) disable iff (srst)
    stateR == S_SUSP |-> opErase && opKind != K_DIE)
    else $error("bad suspend");
  // chk_timeout_sets_fail
  chk_timeout_sets_fail: assert property (@(posedge core_clk) disable iff (srst)
    clkEn && stateR == S_BUSY && toR >= 32'(TIMEOUT_CYCLES) && opErase && !frameEnd
    |=> flagStatus[FL_EFAIL])
    else $error("timeout without erase error");
endmodule

//--- sfps_host_model.sv
`timescale 1ns/1ns
module sfps_host_model (
  output logic linkClk,
  output logic selectN,
  output logic [3:0] dqIn
);
  // idle: select high, clock parked low
  initial begin
    linkClk = 1'b0;
    selectN = 1'b1;
    dqIn = 4'h5;
  end
  // one frame, msb first; extra bits break the byte boundary
  task automatic send(input logic [63:0] w, input int nb, input int extra,
    input logic [1:0] mode);
    int ln;
    logic [63:0] sh;
    ln = (mode == 2'h2) ? 4 : (mode == 2'h1) ? 2 : 1;
    sh = w << (64 - 8 * nb);
    #1 selectN = 1'b0;
    for (int i = 0; i < (8 * nb + extra) / ln; i++) begin
      dqIn = sh[63:60] >> (4 - ln);
      sh = sh << ln;
      #3 linkClk = 1'b1;
      #3 linkClk = 1'b0;
    end
    #3 selectN = 1'b1;
    // released lines must not look like stale data
    dqIn = ~dqIn;
  endtask
endmodule

//--- sfps_sequencer_tb.sv
`timescale 1ns/1ns
module sfps_sequencer_tb;
  import sfps_pkg::*;
  // short counts keep the run brief
  localparam int PB = 16;
  localparam int PP = 20;
  localparam int SSE = 30;
  localparam int SE = 40;
  localparam int DE = 50;
  localparam int TO = 200;
  logic core_clk, srst, clkEn, linkClk, selectN, cfgAddr4;
  logic protectHit, anyLocked, arrayStall, writeEnable, writeInProgress;
  logic addr4Active, opStart, opDone, opErase, pageWrite;
  logic [3:0] dqIn;
  logic [1:0] lineMode;
  logic [7:0] flagStatus, pageData, pageIndex, fl;
  logic [7:0] mem [PB];
  logic [31:0] fullWordAddress;
  sfps_kind_t opKind;
  int fails, checked, cyc, nStart, tStart, tDone, s;
  logic [7:0] ops [5] = '{OP_SUB_ERASE, OP_SEC_ERASE, OP_DIE_ERASE, OP_SUB_ERASE4, OP_SEC_ERASE4};
  sfps_kind_t kinds [5] = '{K_SUB, K_SEC, K_DIE, K_SUB, K_SEC};
  int durs [5] = '{SSE, SE, DE, SSE, SE};
  sfps_sequencer #(.PAGE_BYTES(PB), .PP_CYCLES(PP), .SSE_CYCLES(SSE), .SE_CYCLES(SE),
    .DE_CYCLES(DE), .TIMEOUT_CYCLES(TO)) dut (.core_clk(core_clk), .srst(srst),
    .clkEn(clkEn), .linkClk(linkClk), .selectN(selectN), .dqIn(dqIn), .lineMode(lineMode),
    .cfgAddr4(cfgAddr4), .protectHit(protectHit), .anyLocked(anyLocked),
    .arrayStall(arrayStall), .writeEnable(writeEnable), .writeInProgress(writeInProgress),
    .flagStatus(flagStatus), .addr4Active(addr4Active), .opStart(opStart), .opDone(opDone),
    .opErase(opErase), .opKind(opKind), .fullWordAddress(fullWordAddress),
    .pageData(pageData), .pageIndex(pageIndex), .pageWrite(pageWrite));
  sfps_host_model host (.linkClk(linkClk), .selectN(selectN), .dqIn(dqIn));
  always #2 core_clk = ~core_clk;
  // log of pulses and page bytes
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (opStart === 1'b1) begin
      nStart <= nStart + 1;
      tStart <= cyc;
    end
    if (opDone === 1'b1) tDone <= cyc;
    if (pageWrite === 1'b1) mem[pageIndex[3:0]] <= pageData;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // frame, then room for the select sync
  task automatic frame(input logic [63:0] w, input int nb, input int extra = 0);
    host.send(w, nb, extra, lineMode);
    repeat (8) @(negedge core_clk);
  endtask
  // bounded wait for busy to drop
  task automatic waitDone(input int bound);
    int n;
    n = 0;
    while (writeInProgress !== 1'b0 && n < bound) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= bound) begin
      chk("wait", 0, 1);
      final_report();
    end
    @(negedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    clkEn = 1'b1;
    lineMode = 2'h0;
    cfgAddr4 = 1'b0;
    protectHit = 1'b0;
    anyLocked = 1'b0;
    arrayStall = 1'b0;
    fails = 0;
    checked = 0;
    cyc = 0;
    nStart = 0;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    chk("flags", FLAG_RST, flagStatus);
    chk("latch", 0, writeEnable);
    frame({32'h0, OP_SUB_ERASE, 24'h001000}, 4);
    chk("starts", 0, nStart);
    // each erase kind, 3 and 4 byte forms
    for (int k = 0; k < 5; k++) begin
      frame(OP_WRITE_EN, 1);
      frame(k > 2 ? {24'h0, ops[k], 32'h01012345} : {32'h0, ops[k], 24'h012345}, k > 2 ? 5 : 4);
      chk("busy", 1, writeInProgress);
      chk("ready", 0, flagStatus[FL_READY]);
      chk("kind", 32'(kinds[k]), 32'(opKind));
      chk("erase", 1, opErase);
      if (k != 2) chk("addr", k > 2 ? 32'h01012345 : 32'h12345, fullWordAddress);
      waitDone(99);
      chk("time", 1, 32'(tDone - tStart >= durs[k] && tDone - tStart <= durs[k] + 2));
      chk("latch", 0, writeEnable);
      chk("flags", FLAG_RST, flagStatus);
    end
    // select raised off the byte boundary
    frame(OP_WRITE_EN, 1);
    s = nStart;
    frame({32'h0, OP_SEC_ERASE, 24'h0}, 4, 1);
    chk("starts", s, nStart);
    chk("latch", 1, writeEnable);
    chk("flags", FLAG_RST, flagStatus);
    // protected erase, locked die, protected program
    for (int k = 0; k < 3; k++) begin
      protectHit = k != 1;
      anyLocked = k == 1;
      s = nStart;
      fl = 8'h82 | (k == 2 ? 8'h10 : 8'h20);
      frame(OP_WRITE_EN, 1);
      frame(k == 2 ? {24'h0, OP_PAGE_PROG, 32'h01000055} :
        {32'h0, k == 1 ? OP_DIE_ERASE : OP_SUB_ERASE, 24'h010000}, k == 2 ? 5 : 4);
      chk("starts", s, nStart);
      chk("flags", fl, flagStatus);
      chk("latch", 1, writeEnable);
      frame(OP_CLR_FLAGS, 1);
      chk("flags", FLAG_RST, flagStatus);
    end
    protectHit = 1'b0;
    anyLocked = 1'b0;
    // program on one, two and four lines, wrapping the page
    for (int m = 0; m < 3; m++) begin
      lineMode = 2'(m);
      frame(OP_WRITE_EN, 1);
      frame({m == 2 ? OP_QUAD_PROG4 : OP_PROG4, 32'h0000120e, 8'ha1, 8'(m), 8'hc3}, 8);
      chk("addr", 32'h120e, fullWordAddress);
      chk("kind", 32'(K_PROG), 32'(opKind));
      waitDone(99);
      chk("time", 1, 32'(tDone - tStart >= PP && tDone - tStart <= PP + 2));
      chk("wrap", {8'ha1, 8'(m), 8'hc3}, {mem[14], mem[15], mem[0]});
    end
    lineMode = 2'h0;
    // address width by command and by config bit
    frame(OP_ENTER4, 1);
    chk("a4", 1, addr4Active);
    frame(OP_WRITE_EN, 1);
    frame({24'h0, OP_SUB_ERASE, 32'h0a0b0c0d}, 5);
    chk("addr", 32'h0a0b0c0d, fullWordAddress);
    waitDone(99);
    frame(OP_EXIT4, 1);
    chk("a4", 0, addr4Active);
    cfgAddr4 = 1'b1;
    frame(OP_WRITE_EN, 1);
    chk("a4", 1, addr4Active);
    cfgAddr4 = 1'b0;
    frame(OP_EXIT4, 1);
    chk("a4", 0, addr4Active);
    // stalled array: busy refusal, then time limit
    arrayStall = 1'b1;
    for (int k = 0; k < 2; k++) begin
      frame(OP_WRITE_EN, 1);
      frame(k ? {24'h0, OP_PAGE_PROG, 32'h00000077} : {32'h0, OP_SUB_ERASE, 24'h0}, k ? 5 : 4);
      s = nStart;
      lineMode = 2'h2;
      frame({32'h0, OP_SUB_ERASE, 24'h0}, 4);
      lineMode = 2'h0;
      chk("starts", s, nStart);
      waitDone(TO + 50);
      chk("fail", 1, flagStatus[k ? FL_PFAIL : FL_EFAIL]);
      chk("latch", 0, writeEnable);
      frame(OP_CLR_FLAGS, 1);
    end
    // suspend and resume a sector erase
    frame(OP_WRITE_EN, 1);
    frame({32'h0, OP_SEC_ERASE, 24'h0}, 4);
    frame(OP_SUSPEND, 1);
    chk("susp", 1, flagStatus[FL_ESUSP]);
    arrayStall = 1'b0;
    frame(OP_RESUME, 1);
    chk("susp", 0, flagStatus[FL_ESUSP]);
    waitDone(TO);
    chk("latch", 0, writeEnable);
    chk("flags", FLAG_RST, flagStatus);
    final_report();
  end
endmodule
